/* File: src/cobp_delay.sv */
// Delay stage that holds back an event for a programmed number of generator periods.
`timescale 1ns/1ps
module cobp_delay
    import cobp_pkg::*;
(
    input wire logic clock,     // System clock.
    input wire logic rst_b,     // Asynchronous reset, active low.
    cobp_link_if.stage link     // Event, count and result.
);
    cobp_state_t state;         // Idle or counting.
    logic [CNT_W-1:0] remain;   // Periods still to wait.
    logic out_q;                // Registered delayed event.
    wire zero_cnt = (link.count == CNT_ZERO);   // No delay requested.
    wire last_tick = link.tick && (remain == CNT_ONE);  // Final period elapses.
    assign link.event_out = out_q;
    assign link.busy = (state == COBP_COUNT);

    // A new event restarts the wait; zero count passes the event at once.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= COBP_IDLE;
            remain <= CNT_INIT;
            out_q <= 1'b0;
        end else begin
            out_q <= 1'b0;
            case (state)
                COBP_IDLE: begin
                    if (link.event_in && zero_cnt) begin
                        out_q <= 1'b1;  // Pass through with no added delay.
                    end else if (link.event_in) begin
                        remain <= link.count;
                        state <= COBP_COUNT;
                    end
                end
                COBP_COUNT: begin
                    if (link.event_in && zero_cnt) begin
                        out_q <= 1'b1;  // A newer event supersedes the pending one.
                        state <= COBP_IDLE;
                    end else if (link.event_in) begin
                        remain <= link.count;
                    end else if (last_tick) begin
                        out_q <= 1'b1;
                        state <= COBP_IDLE;
                    end else if (link.tick) begin
                        remain <= remain - CNT_ONE;
                    end
                end
                default: state <= COBP_IDLE;
            endcase
        end
    end
endmodule : cobp_delay

/* File: src/cobp_link_if.sv */
// Interface carrying one event, its count and delay outcome to a delay stage.
`timescale 1ns/1ps
interface cobp_link_if;
    import cobp_pkg::*;
    logic tick;              // Generator clock period enable.
    logic event_in;          // Accepted event pulse.
    logic [CNT_W-1:0] count; // Delay in generator clock periods.
    logic event_out;         // Delayed event pulse.
    logic busy;              // Delay in progress.
    modport stage (input tick, input event_in, input count, output event_out, output busy);
    modport owner (output tick, output event_in, output count, input event_out, input busy);
endinterface : cobp_link_if

/* File: src/cobp_pkg.sv */
// Package with register map, field layout and widths for the blanking and phase block.
package cobp_pkg;
    localparam int ADDR_W = 4;            // Register address width.
    localparam int DATA_W = 8;            // Register data width.
    localparam int CNT_W = 4;             // Count field width.
    localparam logic [3:0] OFF_RISE_BLANK = 4'h0;  // Rising blanking count register.
    localparam logic [3:0] OFF_FALL_BLANK = 4'h1;  // Falling blanking count register.
    localparam logic [3:0] OFF_RISE_PHASE = 4'h2;  // Rising phase delay register.
    localparam logic [3:0] OFF_FALL_PHASE = 4'h3;  // Falling phase delay register.
    localparam logic [3:0] OFF_STATUS = 4'h4;      // Live status register.
    localparam int FIELD_LSB = 0;         // Low bit of each count field.
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;   // Read value of unmapped offsets.
    localparam logic [3:0] CNT_ZERO = 4'h0;        // Zero count.
    localparam logic [3:0] CNT_ONE = 4'h1;         // Unit step of a count.
    localparam logic [3:0] CNT_INIT = 4'h0;        // Value taken by counters at reset.
    // Status bit positions.
    localparam int ST_RISE_BLANK = 0;     // Rising events blanked.
    localparam int ST_FALL_BLANK = 1;     // Falling events blanked.
    localparam int ST_RISE_WAIT = 2;      // Rising delay in progress.
    localparam int ST_FALL_WAIT = 3;      // Falling delay in progress.
    typedef enum logic {COBP_IDLE, COBP_COUNT} cobp_state_t;  // Delay line state.
endpackage : cobp_pkg

/* File: src/cobp_top.sv */
// Blanking and phase delay stage of a complementary output waveform generator.
`timescale 1ns/1ps
module cobp_top
    import cobp_pkg::*;
#(
    parameter int DIV = 1       // System clocks per generator clock period.
)
(
    input wire logic clock,                 // System clock, 125 MHz.
    input wire logic rst_b,                 // Asynchronous reset, active low.
    input wire logic [ADDR_W-1:0] addr,     // Register address.
    input wire logic [DATA_W-1:0] wdata,    // Write data.
    input wire logic wr,                    // Write strobe.
    input wire logic rd,                    // Read strobe.
    output logic [DATA_W-1:0] rdata,        // Read data, one cycle after rd.
    input wire logic rise_event,            // Rising event input pulse or level.
    input wire logic fall_event,            // Falling event input pulse or level.
    output logic rise_out,                  // Delayed rising event pulse.
    output logic fall_out                   // Delayed falling event pulse.
);
    // Refuse a divider the logic cannot serve.
    initial begin
        if (DIV < 1 || DIV > 65536) begin
            $error("DIV must lie between 1 and 65536.");
        end
    end

    // Count fields; no reset so prior values survive ordinary resets.
    logic [CNT_W-1:0] rise_blank_count;     // Rising event blanking count.
    logic [CNT_W-1:0] fall_blank_count;     // Falling event blanking count.
    logic [CNT_W-1:0] rise_phase_count;     // Rising phase delay count.
    logic [CNT_W-1:0] fall_phase_count;     // Falling phase delay count.

    logic [15:0] div_cnt;                   // Generator period divider.
    logic tick;                             // One cycle per generator period.
    logic rise_q;                           // Previous rising input level.
    logic fall_q;                           // Previous falling input level.
    logic [CNT_W-1:0] rise_blank_left;      // Periods left blanking falls.
    logic [CNT_W-1:0] fall_blank_left;      // Periods left blanking rises.

    // Write decode for each count register.
    wire wr_rb = wr && (addr == OFF_RISE_BLANK);
    wire wr_fb = wr && (addr == OFF_FALL_BLANK);
    wire wr_rp = wr && (addr == OFF_RISE_PHASE);
    wire wr_fp = wr && (addr == OFF_FALL_PHASE);
    wire [CNT_W-1:0] wfield = wdata[FIELD_LSB +: CNT_W];  // Upper bits dropped.

    // Edges of the event inputs.
    wire rise_edge = rise_event && !rise_q;
    wire fall_edge = fall_event && !fall_q;
    // Blanking gates: a non-zero window suppresses the opposite input.
    wire fall_blanked = (rise_blank_left != CNT_ZERO);
    wire rise_blanked = (fall_blank_left != CNT_ZERO);
    wire rise_ok = rise_edge && !rise_blanked;
    wire fall_ok = fall_edge && !fall_blanked;

    cobp_link_if rise_link ();              // Rising delay stage link.
    cobp_link_if fall_link ();              // Falling delay stage link.

    assign rise_link.tick = tick;
    assign rise_link.event_in = rise_ok;
    assign rise_link.count = rise_phase_count;
    assign fall_link.tick = tick;
    assign fall_link.event_in = fall_ok;
    assign fall_link.count = fall_phase_count;

    // Rising edge phase delay.
    cobp_delay u_rise (
        .clock (clock),
        .rst_b (rst_b),
        .link (rise_link.stage)
    );

    // Falling edge phase delay.
    cobp_delay u_fall (
        .clock (clock),
        .rst_b (rst_b),
        .link (fall_link.stage)
    );

    // Status word showing the block's live state.
    wire [DATA_W-1:0] status = {{(DATA_W-4){1'b0}}, fall_link.busy, rise_link.busy,
                                fall_blanked, rise_blanked};

    // Read selection; upper field bits always read as zero.
    wire [DATA_W-1:0] read_mux =
        (addr == OFF_RISE_BLANK) ? {{(DATA_W-CNT_W){1'b0}}, rise_blank_count} :
        (addr == OFF_FALL_BLANK) ? {{(DATA_W-CNT_W){1'b0}}, fall_blank_count} :
        (addr == OFF_RISE_PHASE) ? {{(DATA_W-CNT_W){1'b0}}, rise_phase_count} :
        (addr == OFF_FALL_PHASE) ? {{(DATA_W-CNT_W){1'b0}}, fall_phase_count} :
        (addr == OFF_STATUS) ? status : UNMAPPED_VAL;

    // Count registers: written by software, untouched by reset.
    always_ff @(posedge clock) begin
        if (wr_rb) rise_blank_count <= wfield;
        if (wr_fb) fall_blank_count <= wfield;
        if (wr_rp) rise_phase_count <= wfield;
        if (wr_fp) fall_phase_count <= wfield;
    end

    // Read data register, valid only in the cycle after the strobe.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= UNMAPPED_VAL;
        end else begin
            rdata <= rd ? read_mux : UNMAPPED_VAL;
        end
    end

    // Generator clock divider.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (div_cnt == 16'(DIV - 1)) begin
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Input edge history.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= rise_event;
            fall_q <= fall_event;
        end
    end

    // Blanking window after an accepted rising event; zero gives none.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rise_blank_left <= CNT_INIT;
        end else if (rise_ok) begin
            rise_blank_left <= rise_blank_count;
        end else if (tick && fall_blanked) begin
            rise_blank_left <= rise_blank_left - CNT_ONE;
        end
    end

    // Blanking window after an accepted falling event; zero gives none.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fall_blank_left <= CNT_INIT;
        end else if (fall_ok) begin
            fall_blank_left <= fall_blank_count;
        end else if (tick && rise_blanked) begin
            fall_blank_left <= fall_blank_left - CNT_ONE;
        end
    end

    // Outputs registered once more so they come straight from flip-flops.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            rise_out <= rise_link.event_out;
            fall_out <= fall_link.event_out;
        end
    end
endmodule : cobp_top

/* File: testbench/cobp_src_model.sv */
// Event source model driving the rising and falling event inputs.
`timescale 1ns/1ps
module cobp_src_model (
    input wire logic clock, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic [1:0] fire, // Request, bit 0 rising, bit 1 falling.
    output logic [1:0] ev // Event levels.
);
    logic [1:0] hold; // Second cycle of each level.
    // Each request gives a two-cycle level, so every edge is clean.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ev <= 2'b00;
            hold <= 2'b00;
        end else begin
            ev <= fire | hold;
            hold <= fire;
        end
    end
endmodule : cobp_src_model

/* File: testbench/cobp_top_sva.sv */
// Port checker for the blanking and phase block.
`timescale 1ns/1ps
module cobp_chk
    import cobp_pkg::*;
#(
    parameter int DIV = 1 // System clocks per period.
)
(
    input wire logic clock, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic [ADDR_W-1:0] addr, // Address.
    input wire logic [DATA_W-1:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    input wire logic [DATA_W-1:0] rdata, // Read data.
    input wire logic rise_event, // Rising input.
    input wire logic fall_event, // Falling input.
    input wire logic rise_out, // Rising output.
    input wire logic fall_out // Falling output.
);
    logic [3:0] shadow [4]; // Copy of the written count fields.
    logic [19:0] raw_r; // Past samples of the rising input.
    logic [19:0] raw_f; // Past samples of the falling input.
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Mirror count writes; not reset, like the fields themselves.
    always_ff @(posedge clock) begin
        if (wr && addr < OFF_STATUS) begin
            shadow[addr[1:0]] <= wdata[3:0];
        end
    end
    // Keep input history so an output can be traced to its edge.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            raw_r <= '0;
            raw_f <= '0;
        end else begin
            raw_r <= {raw_r[18:0], rise_event};
            raw_f <= {raw_f[18:0], fall_event};
        end
    end
    sequence s_read; $past(rd); endsequence
    property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    property p_upper; s_read |-> rdata[7:4] == 4'h0; endproperty
    property p_back;
        s_read and ($past(addr) < OFF_STATUS) |-> rdata[3:0] == shadow[$past(addr[1:0])];
    endproperty
    property p_unmap; s_read and ($past(addr) > OFF_STATUS) |-> rdata == UNMAPPED_VAL; endproperty
    // An output pulse seen here traces back N + 1 samples to the first high input sample.
    property p_rise_lat; rise_out |-> raw_r[shadow[2]+5'd1] && !raw_r[shadow[2]+5'd2]; endproperty
    property p_fall_lat; fall_out |-> raw_f[shadow[3]+5'd1] && !raw_f[shadow[3]+5'd2]; endproperty
    property p_pulse; rise_out |=> !rise_out; endproperty
    property p_quiet; $rose(rst_b) |-> !rise_out && !fall_out; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    a_upper: assert property (p_upper) else $error("upper bits set");
    a_back: assert property (p_back) else $error("readback wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_rise_lat: assert property (p_rise_lat) else $error("rise delay");
    a_fall_lat: assert property (p_fall_lat) else $error("fall delay");
    a_pulse: assert property (p_pulse) else $error("rise pulse long");
    a_quiet: assert property (p_quiet) else $error("output after reset");
endmodule : cobp_chk
bind cobp_top cobp_chk #(.DIV(DIV)) u_chk (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rise_event(rise_event),
    .fall_event(fall_event), .rise_out(rise_out), .fall_out(fall_out));

/* File: testbench/testbench.sv */
// Self-checking bench for the blanking and phase block.
`timescale 1ns/1ps
module testbench;
    import cobp_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] fire = 2'b00;
    logic [1:0] ev;
    logic [1:0] outv;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    cobp_src_model u_src (.clock(clock), .rst_b(rst_b), .fire(fire), .ev(ev));
    cobp_top #(.DIV(1)) u_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rise_event(ev[0]), .fall_event(ev[1]),
        .rise_out(outv[0]), .fall_out(outv[1]));
    initial begin
        forever #4 clock = ~clock;
    end
    // Compare one value and count it.
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // One bus cycle; a read returns the data of the following cycle.
    task automatic bus(logic w, logic [3:0] a, logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask : bus
    // Fire one event and count edges until its output, lim + 1 if none.
    task automatic pulse(int d, int lim, output int n);
        @(posedge clock);
        fire[d] <= 1'b1;
        @(posedge clock);
        fire[d] <= 1'b0;
        for (n = 1; n <= lim; n++) begin
            @(posedge clock);
            #1;
            if (outv[d] === 1'b1) break;
        end
    endtask : pulse
    // Fields keep four bits, unmapped space reads zero, counts survive reset.
    task automatic t_regs();
        logic [7:0] q;
        for (int i = 0; i < 4; i++) bus(1'b1, 4'(i), 8'(8'hf3 + i), q);
        bus(1'b1, 4'h9, 8'hff, q);
        bus(1'b0, 4'h9, 8'h00, q);
        check("unmapped", q, 8'h00);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i), 8'h00, q);
            check("field", q, 8'(8'h03 + i));
        end
    endtask : t_regs
    // Output delay follows the phase count, zero included.
    task automatic t_phase();
        int ns[3] = '{0, 1, 15};
        int n;
        logic [7:0] q;
        bus(1'b1, OFF_RISE_BLANK, 8'h00, q);
        bus(1'b1, OFF_FALL_BLANK, 8'h00, q);
        for (int d = 0; d < 2; d++) begin
            foreach (ns[k]) begin
                bus(1'b1, 4'(2 + d), 8'(ns[k]), q);
                pulse(d, 30, n);
                check("delay", 8'(n), 8'(ns[k] + 2));
            end
        end
    endtask : t_phase
    // An opposite event inside the window is dropped, later ones pass.
    task automatic t_blank();
        int n;
        logic [7:0] q;
        bus(1'b1, OFF_RISE_PHASE, 8'h00, q);
        bus(1'b1, OFF_FALL_PHASE, 8'h00, q);
        for (int d = 0; d < 2; d++) begin
            bus(1'b1, 4'(d), 8'h08, q);
            pulse(d, 10, n);
            // The open window shows in the status word while it runs.
            bus(1'b0, OFF_STATUS, 8'h00, q);
            check("status", q, 8'(1 << (d == 0 ? ST_FALL_BLANK : ST_RISE_BLANK)));
            pulse(1 - d, 20, n);
            check("blanked", 8'(n), 8'd21);
            pulse(1 - d, 20, n);
            check("after", 8'(n), 8'd2);
            bus(1'b1, 4'(d), 8'h00, q);
            pulse(d, 10, n);
            pulse(1 - d, 20, n);
            check("no window", 8'(n), 8'd2);
        end
    endtask : t_blank
    // Cut a hang short.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_phase();
        t_blank();
        summarize();
    end
endmodule : testbench
